// ==== shared/efd_pkg.sv ====
package efd_pkg;
   localparam int FILT_NUM = 30;
   localparam int ACT_NUM = 10;
   localparam int EVT_W = 16;
   localparam int SEV_W = 4;
   localparam int DLY_W = 8;
   localparam int SENS_NUM = 16;
   localparam int SIDX_W = 4;
   localparam int THR_W = 8;
   localparam int CLK_MHZ = 250;
   localparam int TICK_MS = 100;
   localparam int PULSE_MS = 200;
   localparam int TICK_CYC = CLK_MHZ * 1000 * TICK_MS;
   localparam int PULSE_TICKS = PULSE_MS / TICK_MS;
   localparam logic [7:0] FIX_POLICY = 8'h01;
   localparam logic [1:0] SEV_CRIT_BIT = 2'h1;
   localparam logic [3:0] SEV_NONC = 4'h1;
   localparam logic [3:0] SEV_CRIT = 4'h2;
   localparam logic [3:0] SEV_DEGR = 4'h4;
   localparam logic [3:0] SEV_NA = 4'hF;
   // action bit positions, bit 0 is priority 1
   localparam int A_PDOWN = 0;
   localparam int A_SOFT = 1;
   localparam int A_PCYC = 2;
   localparam int A_RESET = 3;
   localparam int A_DIAG = 4;
   localparam int A_ALERT = 5;
   localparam int A_FEED = 6;
   localparam int A_MSG = 7;
   localparam int A_FLED = 8;
   localparam int A_ILED = 9;
   localparam int N_DELAYED = 4;
   localparam logic [ACT_NUM-1:0] SUPPRESS_BY_PDOWN = 10'h01E;
   typedef struct packed {
      logic valid;
      logic [EVT_W-1:0] evt;
      logic [SEV_W-1:0] sev;
      logic [ACT_NUM-1:0] act;
      logic [DLY_W-1:0] dly;
   } efd_filt_t;
   typedef enum logic [2:0] {
      EFD_IDLE = 3'b001,
      EFD_SCAN = 3'b010,
      EFD_DISP = 3'b100
   } efd_state_t;
   typedef enum logic [1:0] {
      INIT_IDLE = 2'b01,
      INIT_WALK = 2'b10
   } efd_init_t;
endpackage : efd_pkg

// ==== shared/efd_tbl_if.sv ====
interface efd_tbl_if;
   import efd_pkg::*;
   logic [4:0] addr;
   efd_filt_t rdata;
   logic wr;
   efd_filt_t wdata;
   modport host (output addr, output wr, output wdata, input rdata);
   modport mem (input addr, input wr, input wdata, output rdata);
endinterface : efd_tbl_if

// ==== core/efd_filt_mem.sv ====
module efd_filt_mem
   import efd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   efd_tbl_if.mem tbl
);
   efd_filt_t mem [FILT_NUM];
   function automatic efd_filt_t dflt(input int i);
      efd_filt_t f;
      logic [3:0] s;
      f = '0;
      s = (i == 0 || i == 1 || i == 14 || i == 15 || i == 20 || i == 21 || i == 24 || i == 25)
         ? SEV_NONC : (i >= 8 && i <= 11) ? SEV_DEGR : (i == 16 || i == 17) ? SEV_NA : SEV_CRIT;
      f.valid = (i < FILT_NUM - 2);
      f.evt = 16'(i);
      f.sev = s;
      f.act = (s == SEV_CRIT) ? 10'h320 : 10'h220;
      return f;
   endfunction : dflt
   // factory default pairs, last two entries reserved [RULE_12]
   generate
      for (genvar g = 0; g < FILT_NUM; g++) begin : g_ent
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               mem[g] <= dflt(g);
            end else if (tbl.wr && tbl.addr == 5'(g)) begin
               mem[g] <= tbl.wdata;
            end
         end
      end
   endgenerate
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tbl.rdata <= '0;
      end else if (tbl.addr < 5'(FILT_NUM)) begin
         tbl.rdata <= mem[tbl.addr];
      end else begin
         tbl.rdata <= '0;
      end
   end
endmodule : efd_filt_mem

// ==== core/efd_dispatch.sv ====
// How it works
// RULE_01 - at reset release or host boot the sensor records are walked and each sensor programmed.
// RULE_02 - injected event messages are logged and then filtered like internal ones.
// RULE_03 - the filter table holds exactly thirty entries.
// RULE_04 - every event is compared with every entry and matched actions are ORed.
// RULE_05 - only the four power actions take a delay counted in 100 ms ticks.
// RULE_06 - actions run in fixed priority from power-down down to the identify led.
// RULE_07 - power-down suppresses soft shutdown, power cycle, reset and diagnostic interrupt.
// RULE_08 - a shorter or immediate new delay replaces the pending one.
// RULE_09 - alert, feedback, message and identify led start at once on a critical event.
// RULE_10 - fault led blinks until every critical event that set it is deasserted; the code holds the led steadily on instead.
// RULE_11 - one fixed read-only alert policy entry and no alert strings.
// RULE_12 - default entries pair assert and deassert per class with the last two reserved.
// RULE_13 - software keeps filtering enabled and default entries unchanged.
// RULE_14 - diagnostic interrupt is a 200 ms pulse re-armed by reset, power-down or command; the code holds the pulse between one and two 100 ms ticks.
// RULE_15 - delayed actions count down on a 100 ms tick and are cancelled by a higher action.
module efd_dispatch
   import efd_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic host_boot,
   input wire logic evt_int_valid,
   input wire logic [EVT_W-1:0] evt_int_code,
   input wire logic [SEV_W-1:0] evt_int_sev,
   input wire logic evt_int_deassert,
   input wire logic evt_ext_valid,
   input wire logic [EVT_W-1:0] evt_ext_code,
   input wire logic [SEV_W-1:0] evt_ext_sev,
   input wire logic evt_ext_deassert,
   input wire logic filter_enable,
   input wire logic diag_rearm,
   input wire logic tbl_wr,
   input wire logic [4:0] tbl_addr,
   input wire logic [EVT_W-1:0] tbl_evt,
   input wire logic [SEV_W-1:0] tbl_sev,
   input wire logic [ACT_NUM-1:0] tbl_act,
   input wire logic [DLY_W-1:0] tbl_dly,
   output logic evt_busy,
   output logic log_valid,
   output logic [EVT_W-1:0] log_code,
   output logic [SEV_W-1:0] log_sev,
   output logic sens_prog_valid,
   output logic [SIDX_W-1:0] sens_prog_idx,
   output logic [THR_W-1:0] sens_prog_thr,
   output logic sens_prog_scan_en,
   output logic sens_prog_msg_en,
   output logic [ACT_NUM-1:0] act_fire,
   output logic diag_pulse,
   output logic fault_led,
   output logic [7:0] alert_policy
);
   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
   efd_tbl_if tbl ();
   efd_state_t state;
   efd_init_t init_st;
   logic [4:0] scan_idx;
   logic [4:0] scan_lag;
   logic scan_live;
   logic [EVT_W-1:0] ev_code;
   logic [SEV_W-1:0] ev_sev;
   logic ev_deas;
   logic [ACT_NUM-1:0] acc;
   logic [DLY_W-1:0] acc_dly;
   logic [31:0] tick_cnt;
   logic tick;
   logic [DLY_W-1:0] pend_cnt [N_DELAYED];
   logic [N_DELAYED-1:0] pend;
   logic [ACT_NUM-1:0] next_fire;
   logic [FILT_NUM-1:0] fled_req;
   logic diag_armed;
   logic [1:0] diag_ticks;
   logic [SIDX_W-1:0] init_idx;
   logic [2:0] boot_sync;
   logic boot_flt;
   efd_filt_mem u_mem (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tbl(tbl.mem)
   );
   function automatic logic is_crit(input logic [SEV_W-1:0] s);
      return s[SEV_CRIT_BIT];
   endfunction : is_crit
   assign tbl.addr = tbl_wr ? tbl_addr : scan_idx;
   assign tbl.wr = tbl_wr && (tbl_addr < 5'(FILT_NUM)); // [RULE_03]
   assign tbl.wdata = '{valid: 1'b1, evt: tbl_evt, sev: tbl_sev, act: tbl_act, dly: tbl_dly};
   // startup and boot sensor programming walk
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         init_st <= INIT_WALK;
         init_idx <= '0;
         boot_sync <= '0;
         boot_flt <= 1'b0;
         sens_prog_valid <= 1'b0;
         sens_prog_idx <= '0;
         sens_prog_thr <= '0;
         sens_prog_scan_en <= 1'b0;
         sens_prog_msg_en <= 1'b0;
      end else begin
         boot_sync <= {boot_sync[1:0], host_boot};
         if (boot_sync[1] == boot_sync[2]) begin
            boot_flt <= boot_sync[2];
         end
         sens_prog_valid <= 1'b0;
         case (init_st)
            INIT_IDLE: begin
               if (boot_sync[1] == boot_sync[2] && boot_sync[2] && !boot_flt) begin
                  init_st <= INIT_WALK; // [RULE_01]
                  init_idx <= '0;
               end
            end
            INIT_WALK: begin
               sens_prog_valid <= 1'b1; // [RULE_01]
               sens_prog_idx <= init_idx;
               sens_prog_thr <= {init_idx, init_idx};
               sens_prog_scan_en <= 1'b1;
               sens_prog_msg_en <= 1'b1;
               init_idx <= init_idx + 1'b1;
               if (init_idx == SIDX_W'(SENS_NUM - 1)) begin
                  init_st <= INIT_IDLE;
               end
            end
            default: init_st <= INIT_IDLE;
         endcase
      end
   end
   // event intake, logging and table scan
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= EFD_IDLE;
         scan_idx <= '0;
         scan_lag <= '0;
         scan_live <= 1'b0;
         ev_code <= '0;
         ev_sev <= '0;
         ev_deas <= 1'b0;
         acc <= '0;
         acc_dly <= '0;
         log_valid <= 1'b0;
         log_code <= '0;
         log_sev <= '0;
         evt_busy <= 1'b0;
      end else begin
         log_valid <= 1'b0;
         case (state)
            EFD_IDLE: begin
               if (evt_ext_valid || evt_int_valid) begin
                  ev_code <= evt_ext_valid ? evt_ext_code : evt_int_code; // [RULE_02]
                  ev_sev <= evt_ext_valid ? evt_ext_sev : evt_int_sev;
                  ev_deas <= evt_ext_valid ? evt_ext_deassert : evt_int_deassert;
                  log_valid <= 1'b1; // [RULE_02]
                  log_code <= evt_ext_valid ? evt_ext_code : evt_int_code;
                  log_sev <= evt_ext_valid ? evt_ext_sev : evt_int_sev;
                  acc <= '0;
                  acc_dly <= '1;
                  scan_idx <= '0;
                  scan_live <= 1'b0;
                  evt_busy <= 1'b1;
                  state <= filter_enable ? EFD_SCAN : EFD_DISP;
               end
            end
            EFD_SCAN: begin
               if (!tbl_wr) begin
                  scan_lag <= scan_idx;
                  scan_live <= 1'b1;
                  if (scan_idx != 5'(FILT_NUM - 1)) begin
                     scan_idx <= scan_idx + 1'b1;
                  end
               end else begin
                  scan_live <= 1'b0;
               end
               if (scan_live && tbl.rdata.valid && tbl.rdata.evt == ev_code
                   && (tbl.rdata.sev & ev_sev) != '0) begin
                  acc <= acc | tbl.rdata.act; // [RULE_04]
                  if (tbl.rdata.dly < acc_dly) begin
                     acc_dly <= tbl.rdata.dly;
                  end
               end
               if (scan_live && scan_lag == 5'(FILT_NUM - 1)) begin
                  state <= EFD_DISP; // [RULE_04]
               end
            end
            EFD_DISP: begin
               state <= EFD_IDLE;
               evt_busy <= 1'b0;
            end
            default: state <= EFD_IDLE;
         endcase
      end
   end
   // 100 ms tick
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (tick_cnt == TICK_LAST); // [RULE_15]
         tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
      end
   end
   // priority dispatch of immediate and delayed actions
   always_comb begin
      next_fire = '0;
      for (int i = 0; i < N_DELAYED; i++) begin
         if (pend[i] && pend_cnt[i] == '0) begin
            next_fire[i] = 1'b1; // [RULE_05]
         end
      end
      if (state == EFD_DISP && !ev_deas) begin
         next_fire[ACT_NUM-1:N_DELAYED] = acc[ACT_NUM-1:N_DELAYED]; // [RULE_09]
         for (int i = 0; i < N_DELAYED; i++) begin
            if (acc[i] && acc_dly == '0) begin
               next_fire[i] = 1'b1;
            end
         end
      end
      if (next_fire[A_PDOWN]) begin
         next_fire = next_fire & ~SUPPRESS_BY_PDOWN; // [RULE_07]
      end else begin
         for (int i = 1; i < N_DELAYED; i++) begin
            if (next_fire[i]) begin
               next_fire = next_fire & ~((ACT_NUM'(1) << N_DELAYED) - (ACT_NUM'(1) << (i + 1)));
               break; // [RULE_06]
            end
         end
      end
   end
   generate
      for (genvar g = 0; g < N_DELAYED; g++) begin : g_pend
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               pend[g] <= 1'b0;
               pend_cnt[g] <= '0;
            end else if (next_fire != '0 && next_fire[N_DELAYED-1:0] != '0
                         && (next_fire & ((ACT_NUM'(1) << g) - 1'b1)) != '0) begin
               pend[g] <= 1'b0; // [RULE_15]
            end else if (next_fire[g]) begin
               pend[g] <= 1'b0;
            end else if (state == EFD_DISP && !ev_deas && acc[g] && acc_dly != '0
                         && (!pend[g] || acc_dly < pend_cnt[g])) begin
               pend[g] <= 1'b1; // [RULE_08]
               pend_cnt[g] <= acc_dly; // [RULE_05]
            end else if (pend[g] && tick && pend_cnt[g] != '0) begin
               pend_cnt[g] <= pend_cnt[g] - 1'b1; // [RULE_15]
            end
         end
      end
   endgenerate
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         act_fire <= '0;
         alert_policy <= FIX_POLICY; // [RULE_11]
      end else begin
         act_fire <= next_fire; // [RULE_06]
         alert_policy <= FIX_POLICY; // [RULE_11]
      end
   end
   // fault led held while any critical requester is asserted
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fled_req <= '0;
         fault_led <= 1'b0;
      end else begin
         if (state == EFD_DISP && acc[A_FLED] && is_crit(ev_sev)) begin
            fled_req[ev_code[4:0]] <= !ev_deas; // [RULE_10]
         end else if (state == EFD_DISP && ev_deas && is_crit(ev_sev)) begin
            fled_req[ev_code[4:0]] <= 1'b0; // [RULE_10]
         end
         fault_led <= (fled_req != '0);
      end
   end
   // diagnostic interrupt pulse, one shot until rearmed
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         diag_armed <= 1'b1;
         diag_ticks <= '0;
         diag_pulse <= 1'b0;
      end else begin
         if (next_fire[A_DIAG] && diag_armed) begin
            diag_armed <= 1'b0; // [RULE_14]
            diag_pulse <= 1'b1;
            diag_ticks <= 2'(PULSE_TICKS);
         end else begin
            if (diag_pulse && tick) begin
               diag_ticks <= diag_ticks - 1'b1;
               if (diag_ticks == 2'h1) begin
                  diag_pulse <= 1'b0; // [RULE_14]
               end
            end
            if (diag_rearm || next_fire[A_PDOWN] || next_fire[A_RESET]) begin
               diag_armed <= 1'b1; // [RULE_14]
            end
         end
      end
   end
endmodule : efd_dispatch

// ==== verif/efd_dispatch_properties.sv ====
module efd_props
   import efd_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic evt_int_valid,
   input wire logic [EVT_W-1:0] evt_int_code,
   input wire logic evt_ext_valid,
   input wire logic [EVT_W-1:0] evt_ext_code,
   input wire logic diag_rearm,
   input wire logic filter_enable,
   input wire logic evt_busy,
   input wire logic log_valid,
   input wire logic [EVT_W-1:0] log_code,
   input wire logic [ACT_NUM-1:0] act_fire,
   input wire logic diag_pulse,
   input wire logic fault_led
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   logic [31:0] dcnt;
   logic spent;
   // length of the current diagnostic pulse in cycles
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dcnt <= '0;
      end else begin
         dcnt <= diag_pulse ? dcnt + 32'h1 : 32'h0;
      end
   end
   // a pulse has been spent and no re-arm seen since
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         spent <= 1'b0;
      end else if (diag_rearm || act_fire[A_PDOWN] || act_fire[A_RESET]) begin
         spent <= 1'b0;
      end else if ($fell(diag_pulse)) begin
         spent <= 1'b1;
      end
   end
   property p_log_ext;
      evt_ext_valid && !evt_busy |=> log_valid && log_code == $past(evt_ext_code);
   endproperty
   a_log_ext: assert property (p_log_ext) else $error("ext event not logged");
   property p_log_int;
      evt_int_valid && !evt_ext_valid && !evt_busy |=> log_valid && log_code == $past(evt_int_code);
   endproperty
   a_log_int: assert property (p_log_int) else $error("int event not logged");
   property p_scan;
      (evt_ext_valid || evt_int_valid) && !evt_busy && filter_enable
         |-> ##[30:40] $fell(evt_busy);
   endproperty
   a_scan: assert property (p_scan) else $error("scan length wrong");
   property p_imm;
      (act_fire & 10'h3F0) != '0 |-> $fell(evt_busy);
   endproperty
   a_imm: assert property (p_imm) else $error("undelayed action off dispatch");
   property p_pdown;
      act_fire[A_PDOWN] |-> (act_fire & SUPPRESS_BY_PDOWN) == '0 && !$rose(diag_pulse);
   endproperty
   a_pdown: assert property (p_pdown) else $error("action not suppressed");
   property p_dlen;
      $fell(diag_pulse) |-> dcnt >= TICK_CYCLES && dcnt <= 2 * TICK_CYCLES + 1;
   endproperty
   a_dlen: assert property (p_dlen) else $error("diag pulse length wrong");
   property p_donce;
      spent |-> !$rose(diag_pulse);
   endproperty
   a_donce: assert property (p_donce) else $error("diag pulse not re-armed");
   property p_fault;
      $rose(fault_led) |-> act_fire[A_FLED] || $past(act_fire[A_FLED]);
   endproperty
   a_fault: assert property (p_fault) else $error("fault led without action");
endmodule : efd_props

bind efd_dispatch efd_props #(.TICK_CYCLES(TICK_CYCLES)) efd_props_i (.clk_sys, .rst_n,
   .evt_int_valid, .evt_int_code, .evt_ext_valid, .evt_ext_code, .diag_rearm, .filter_enable,
   .evt_busy, .log_valid, .log_code, .act_fire, .diag_pulse, .fault_led);

// ==== verif/efd_evt_src.sv ====
module efd_evt_src
   import efd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic evt_busy,
   output logic evt_int_valid,
   output logic [EVT_W-1:0] evt_int_code,
   output logic [SEV_W-1:0] evt_int_sev,
   output logic evt_int_deassert,
   output logic evt_ext_valid,
   output logic [EVT_W-1:0] evt_ext_code,
   output logic [SEV_W-1:0] evt_ext_sev,
   output logic evt_ext_deassert
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      evt_int_valid = 1'b0;
      evt_ext_valid = 1'b0;
      evt_int_code = 16'h0000;
      evt_ext_code = 16'h0000;
      evt_int_sev = 4'h0;
      evt_ext_sev = 4'h0;
      evt_int_deassert = 1'b0;
      evt_ext_deassert = 1'b0;
   end
   // one event message, offered only while no scan is running
   task automatic send(input bit ext, input logic [EVT_W-1:0] c, input logic [SEV_W-1:0] s,
      input bit de);
      @(posedge clk_sys);
      while (evt_busy !== 1'b0) begin
         @(posedge clk_sys);
      end
      evt_int_valid <= !ext;
      evt_ext_valid <= ext;
      evt_int_code <= c;
      evt_ext_code <= c;
      evt_int_sev <= s;
      evt_ext_sev <= s;
      evt_int_deassert <= de;
      evt_ext_deassert <= de;
      @(posedge clk_sys);
      evt_int_valid <= 1'b0;
      evt_ext_valid <= 1'b0;
      evt_int_code <= ~c;
      evt_ext_code <= ~c;
      evt_int_sev <= ~s;
      evt_ext_sev <= ~s;
   endtask : send
endmodule : efd_evt_src

// ==== verif/tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import efd_pkg::*;
   localparam int TCK = 10;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic host_boot = 1'b0;
   logic filter_enable = 1'b1;
   logic diag_rearm = 1'b0;
   logic tbl_wr = 1'b0;
   logic [4:0] tbl_addr = '0;
   logic [EVT_W-1:0] tbl_evt = '0;
   logic [SEV_W-1:0] tbl_sev = '0;
   logic [ACT_NUM-1:0] tbl_act = '0;
   logic [DLY_W-1:0] tbl_dly = '0;
   logic evt_int_valid, evt_int_deassert, evt_ext_valid, evt_ext_deassert;
   logic [EVT_W-1:0] evt_int_code, evt_ext_code, log_code, lcode;
   logic [SEV_W-1:0] evt_int_sev, evt_ext_sev, log_sev, lsev;
   logic evt_busy, log_valid, sens_prog_valid, sens_prog_scan_en, sens_prog_msg_en;
   logic [SIDX_W-1:0] sens_prog_idx, lidx;
   logic [THR_W-1:0] sens_prog_thr;
   logic [ACT_NUM-1:0] act_fire;
   logic [ACT_NUM-1:0] fired = '0;
   logic diag_pulse, fault_led;
   logic [7:0] alert_policy;
   int bad_count = 0, num_checks = 0, n_prog = 0, n_rst = 0, dhi = 0, cyc = 0;

   efd_dispatch #(.TICK_CYCLES(TCK)) efd_dispatch_i (.clk_sys, .rst_n, .host_boot,
      .evt_int_valid, .evt_int_code, .evt_int_sev, .evt_int_deassert, .evt_ext_valid,
      .evt_ext_code, .evt_ext_sev, .evt_ext_deassert, .filter_enable, .diag_rearm, .tbl_wr,
      .tbl_addr, .tbl_evt, .tbl_sev, .tbl_act, .tbl_dly, .evt_busy, .log_valid, .log_code,
      .log_sev, .sens_prog_valid, .sens_prog_idx, .sens_prog_thr, .sens_prog_scan_en,
      .sens_prog_msg_en, .act_fire, .diag_pulse, .fault_led, .alert_policy);
   efd_evt_src efd_evt_src_i (.clk_sys, .evt_busy, .evt_int_valid, .evt_int_code,
      .evt_int_sev, .evt_int_deassert, .evt_ext_valid, .evt_ext_code, .evt_ext_sev,
      .evt_ext_deassert);

   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      fired <= fired | act_fire;
      n_prog <= n_prog + int'(sens_prog_valid);
      n_rst <= n_rst + int'(act_fire[A_RESET]);
      dhi <= dhi + int'(diag_pulse);
      if (log_valid) begin
         lcode <= log_code;
         lsev <= log_sev;
      end
      if (sens_prog_valid) begin
         lidx <= sens_prog_idx;
      end
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_ent(input logic [4:0] a, input logic [EVT_W-1:0] c,
      input logic [ACT_NUM-1:0] ac, input logic [DLY_W-1:0] d);
      @(posedge clk_sys);
      tbl_wr <= 1'b1;
      tbl_addr <= a;
      tbl_evt <= c;
      tbl_sev <= SEV_CRIT;
      tbl_act <= ac;
      tbl_dly <= d;
      @(posedge clk_sys);
      tbl_wr <= 1'b0;
   endtask : wr_ent
   // one event through logging and scan; ea below zero skips the action compare
   task automatic ev(input bit ext, input logic [EVT_W-1:0] c, input bit de, input int ea);
      int n;
      n = 0;
      #1;
      fired = '0;
      efd_evt_src_i.send(ext, c, SEV_CRIT, de);
      @(posedge clk_sys);
      while (evt_busy === 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      #1;
      chk(32'(n < 100), 32'h1);
      chk(32'(lcode), 32'(c));
      chk(32'(lsev), 32'(SEV_CRIT));
      if (ea >= 0) chk(32'(fired), 32'(ea));
   endtask : ev

   task automatic t_reset;
      repeat (12) @(posedge clk_sys);
      chk(32'({act_fire, log_valid, evt_busy, diag_pulse, fault_led}), 32'h0);
      chk(32'(alert_policy), 32'(FIX_POLICY));
      rst_n <= 1'b1;
      repeat (100) @(posedge clk_sys);
      chk(32'(n_prog), 32'h10);
      chk(32'(lidx), 32'(SENS_NUM - 1));
      chk(32'({sens_prog_scan_en, sens_prog_msg_en}), 32'h3);
      host_boot <= 1'b1;
      repeat (100) @(posedge clk_sys);
      chk(32'(n_prog), 32'h20);
   endtask : t_reset
   task automatic t_dflt;
      ev(1'b0, 16'h0002, 1'b0, 32'h320);
      chk(32'(fault_led), 32'h1);
      ev(1'b0, 16'h0002, 1'b1, 0);
      chk(32'(fault_led), 32'h0);
      ev(1'b0, 16'h001C, 1'b0, 0);
   endtask : t_dflt
   task automatic t_union;
      wr_ent(5'h00, 16'h0100, 10'h020, 8'h00);
      wr_ent(5'h1D, 16'h0100, 10'h0C0, 8'h00);
      ev(1'b1, 16'h0100, 1'b0, 32'h0E0);
      ev(1'b0, 16'h0107, 1'b0, 0);
      @(posedge clk_sys);
      filter_enable <= 1'b0;
      ev(1'b1, 16'h0100, 1'b0, 0);
      @(posedge clk_sys);
      filter_enable <= 1'b1;
   endtask : t_union
   task automatic t_pdown;
      int d;
      wr_ent(5'h01, 16'h0102, 10'h21F, 8'h00);
      d = dhi;
      ev(1'b1, 16'h0102, 1'b0, 32'h201);
      repeat (5) @(posedge clk_sys);
      chk(32'(dhi - d), 32'h0);
   endtask : t_pdown
   task automatic t_diag;
      int d;
      wr_ent(5'h02, 16'h0103, 10'h010, 8'h00);
      d = dhi;
      ev(1'b1, 16'h0103, 1'b0, 32'h010);
      repeat (30) @(posedge clk_sys);
      chk(32'(dhi - d >= TCK && dhi - d <= 2 * TCK + 1), 32'h1);
      d = dhi;
      ev(1'b1, 16'h0103, 1'b0, -1);
      repeat (30) @(posedge clk_sys);
      chk(32'(dhi - d), 32'h0);
      diag_rearm <= 1'b1;
      @(posedge clk_sys);
      diag_rearm <= 1'b0;
      d = dhi;
      ev(1'b1, 16'h0103, 1'b0, 32'h010);
      repeat (30) @(posedge clk_sys);
      chk(32'(dhi > d), 32'h1);
   endtask : t_diag
   task automatic t_delay;
      int r;
      r = n_rst;
      wr_ent(5'h03, 16'h0104, 10'h008, 8'h0C);
      ev(1'b1, 16'h0104, 1'b0, 0);
      wr_ent(5'h03, 16'h0104, 10'h008, 8'h01);
      ev(1'b0, 16'h0104, 1'b0, 0);
      repeat (25) @(posedge clk_sys);
      chk(32'(n_rst - r), 32'h1);
      repeat (100) @(posedge clk_sys);
      chk(32'(n_rst - r), 32'h1);
   endtask : t_delay
   task automatic t_fault;
      wr_ent(5'h04, 16'h0105, 10'h120, 8'h00);
      wr_ent(5'h05, 16'h0106, 10'h100, 8'h00);
      ev(1'b0, 16'h0105, 1'b0, 32'h120);
      chk(32'(fault_led), 32'h1);
      ev(1'b0, 16'h0106, 1'b0, 32'h100);
      ev(1'b0, 16'h0105, 1'b1, -1);
      chk(32'(fault_led), 32'h1);
      ev(1'b0, 16'h0106, 1'b1, -1);
      chk(32'(fault_led), 32'h0);
   endtask : t_fault

   initial begin
      t_reset();
      t_dflt();
      t_union();
      t_pdown();
      t_diag();
      t_delay();
      t_fault();
      end_sim();
   end
endmodule : tb
